/* File: design/adcs_pkg.sv */
package adcs_pkg;
    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int ADCS_ADDR_W = 12;
    localparam logic [9:0] ADCS_BASE_BLOCK = 10'h200;
    localparam logic [9:0] ADCS_BASE_NONBLOCK = 10'h300;
    localparam logic [7:0] ADCS_OFS_CONFIG = 8'h80;
    localparam logic [7:0] ADCS_OFS_STATUS = 8'h81;
    localparam logic [7:0] ADCS_OFS_MASK = 8'h82;
    localparam logic [7:0] ADCS_OFS_MASK_LO = 8'h83;
    localparam logic [7:0] ADCS_OFS_DONE = 8'h84;
    localparam logic [7:0] ADCS_OFS_DONE_LO = 8'h85;
    localparam logic [7:0] ADCS_OFS_RESULT = 8'h86;
    localparam logic [7:0] ADCS_OFS_RESULT_END = 8'ha5;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int ADCS_STAT_SEQ_DONE = 7;
    localparam int ADCS_STAT_REF_LIMIT = 6;
    localparam int ADCS_CFG_IRQ_EN = 7;
    localparam int ADCS_CFG_REPEAT = 6;
    localparam int ADCS_CFG_OFFSET = 5;
    localparam int ADCS_CFG_SOFT_RST = 4;
    localparam logic [7:0] ADCS_CONFIG_RESET = 8'h00;
    localparam logic [7:0] ADCS_CFG_WMASK = 8'hf7;
    localparam logic [15:0] ADCS_MASK_RESET = 16'h0000;
    localparam logic [15:0] ADCS_DONE_RESET = 16'h0000;
    localparam logic [15:0] ADCS_CH_IMPL = 16'hdfff;
    localparam logic [3:0] ADCS_CNT_RESET = 4'hf;
    localparam logic [3:0] ADCS_FIRST_CH = 4'hf;

    // ------------------------------------------------------------
    // converter clock cycle counts
    // ------------------------------------------------------------
    localparam logic [4:0] ADCS_SAMPLE_CYC = 5'h09;
    localparam logic [4:0] ADCS_CONVERT_CYC = 5'h12;
    localparam logic [4:0] ADCS_GAP_CYC = 5'h04;
    localparam logic [3:0] ADCS_PS_DIV [8] = '{4'ha, 4'h8, 4'h6, 4'h4, 4'h2, 4'h1, 4'h1, 4'h1};

    // ------------------------------------------------------------
    // scan order helpers
    // ------------------------------------------------------------
    // channel after c in scan order; also c's position in the order
    function automatic logic [3:0] adcs_step(input logic [3:0] c);
        return (c == 4'hf) ? 4'h0 : c + 4'h1;
    endfunction

    // {found, channel} of the next selected channel after c
    function automatic logic [4:0] adcs_next_sel(input logic [15:0] m, input logic [3:0] c);
        logic [4:0] r;
        logic [3:0] ch;
        r = 5'h00;
        for (int p = 15; p >= 0; p--) begin
            ch = (p == 0) ? 4'hf : 4'(p - 1);
            if (m[ch] && (4'(p) > adcs_step(c))) begin
                r = {1'b1, ch};
            end
        end
        return r;
    endfunction
endpackage

/* File: design/adcs_link_if.sv */
`timescale 1ns/100ps
interface adcs_link_if;
    logic hold;
    logic [2:0] ps;
    logic tick;
    logic [15:0] mask;
    logic start;
    logic abort;
    logic repeat_en;
    logic [3:0] cnt;
    logic ch_done;
    logic seq_done;
    logic sampling;
    modport divider(input hold, ps, output tick);
    modport engine(input hold, tick, mask, start, abort, repeat_en,
                   output cnt, ch_done, seq_done, sampling);
    modport ctrl(output hold, ps, mask, start, abort, repeat_en,
                 input cnt, ch_done, seq_done, sampling);
endinterface

/* File: design/adcs_divider.sv */
`timescale 1ns/100ps
module adcs_divider #(
    parameter int CNT_W = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    adcs_link_if.divider lnk
);
    import adcs_pkg::*;

    if (CNT_W < 4) begin : g_chk
        $error("divider counter too narrow for the largest ratio");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] last;
    logic tick_r;
    logic tick_nxt;

    // ------------------------------------------------------------
    // converter clock enable
    // ------------------------------------------------------------
    // a ratio change mid-count is caught by the >= compare
    always_comb begin
        last = CNT_W'(ADCS_PS_DIV[lnk.ps] - 4'h1);
        cnt_nxt = cnt_r + 1'b1;
        tick_nxt = 1'b0;
        if (lnk.hold) begin
            cnt_nxt = '0;
        end else if (cnt_r >= last) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign lnk.tick = tick_r;
endmodule

/* File: design/adcs_engine.sv */
`timescale 1ns/100ps
module adcs_engine (
    input wire logic clk,
    input wire logic rst_n,
    adcs_link_if.engine lnk
);
    import adcs_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_COUNT, ST_SAMPLE, ST_CONVERT, ST_GAP} adcs_state_type;

    adcs_state_type state_r;
    adcs_state_type state_nxt;
    logic [4:0] cyc_r;
    logic [4:0] cyc_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic ch_done_r;
    logic ch_done_nxt;
    logic seq_done_r;
    logic seq_done_nxt;
    logic sampling_r;
    logic [4:0] nx;

    // ------------------------------------------------------------
    // scan sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cyc_nxt = cyc_r;
        cnt_nxt = cnt_r;
        ch_done_nxt = 1'b0;
        seq_done_nxt = 1'b0;
        nx = adcs_next_sel(lnk.mask, cnt_r);
        if (lnk.hold) begin
            state_nxt = ST_IDLE;
            cyc_nxt = 5'h00;
            cnt_nxt = ADCS_CNT_RESET;
        end else if (lnk.start) begin
            state_nxt = ST_COUNT;
            cyc_nxt = 5'h00;
            cnt_nxt = ADCS_FIRST_CH;
        end else if (lnk.abort) begin
            state_nxt = ST_IDLE;
            cyc_nxt = 5'h00;
        end else if (lnk.tick) begin
            unique case (state_r)
                ST_IDLE: begin
                end
                ST_COUNT: begin
                    // one converter cycle per channel walked past
                    if (lnk.mask[cnt_r]) begin
                        state_nxt = ST_SAMPLE;
                    end else begin
                        cnt_nxt = adcs_step(cnt_r);
                    end
                end
                ST_SAMPLE: begin
                    if (cyc_r == ADCS_SAMPLE_CYC - 5'h01) begin
                        state_nxt = ST_CONVERT;
                        cyc_nxt = 5'h00;
                    end else begin
                        cyc_nxt = cyc_r + 5'h01;
                    end
                end
                ST_CONVERT: begin
                    if (cyc_r == ADCS_CONVERT_CYC - 5'h01) begin
                        ch_done_nxt = 1'b1;
                        seq_done_nxt = !nx[4];
                        cyc_nxt = 5'h00;
                        state_nxt = (nx[4] || lnk.repeat_en) ? ST_GAP : ST_IDLE;
                    end else begin
                        cyc_nxt = cyc_r + 5'h01;
                    end
                end
                ST_GAP: begin
                    if (cyc_r == ADCS_GAP_CYC - 5'h01) begin
                        cyc_nxt = 5'h00;
                        // walk to the next channel is hidden in the gap time
                        if (nx[4]) begin
                            state_nxt = ST_SAMPLE;
                            cnt_nxt = nx[3:0];
                        end else begin
                            state_nxt = ST_COUNT;
                            cnt_nxt = ADCS_FIRST_CH;
                        end
                    end else begin
                        cyc_nxt = cyc_r + 5'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cyc_r <= 5'h00;
            cnt_r <= ADCS_CNT_RESET;
            ch_done_r <= 1'b0;
            seq_done_r <= 1'b0;
            sampling_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cyc_r <= cyc_nxt;
            cnt_r <= cnt_nxt;
            ch_done_r <= ch_done_nxt;
            seq_done_r <= seq_done_nxt;
            sampling_r <= (state_nxt == ST_SAMPLE);
        end
    end

    assign lnk.cnt = cnt_r;
    assign lnk.ch_done = ch_done_r;
    assign lnk.seq_done = seq_done_r;
    assign lnk.sampling = sampling_r;
endmodule

/* File: design/adcs_top.sv */
`timescale 1ns/100ps
module adcs_top #(
    parameter int RES_W = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [adcs_pkg::ADCS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [RES_W-1:0] ana_result,
    input wire logic ref_limit_pin,
    output logic [3:0] ana_channel,
    output logic ana_sample,
    output logic offset_comp_en,
    output logic irq
);
    import adcs_pkg::*;

    localparam int PAD_W = 16 - RES_W;

    if (RES_W < 8 || RES_W > 15) begin : g_chk
        $error("result width must be 8 to 15 bits");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // odd offset is the low byte alone, in lane 0
    function automatic logic [31:0] rd16(input logic [15:0] v, input logic odd);
        return odd ? {24'h000000, v[7:0]} : {16'h0000, v};
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic [15:0] mask_r;
    logic [15:0] mask_nxt;
    logic [15:0] done_r;
    logic [15:0] done_nxt;
    logic scf_r;
    logic scf_nxt;
    logic lim_r;
    logic lim_nxt;
    logic [RES_W-1:0] res_r [16];
    logic [RES_W-1:0] res_nxt [16];
    logic [7:0] lat_hi_r;
    logic [7:0] lat_hi_nxt;
    logic [3:0] lat_ch_r;
    logic [3:0] lat_ch_nxt;
    logic lat_vld_r;
    logic lat_vld_nxt;
    logic start_r;
    logic start_nxt;
    logic abort_r;
    logic abort_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wait_r;
    logic wait_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [RES_W:0] s1_r;
    logic [RES_W:0] s2_r;
    logic [RES_W:0] s3_r;
    logic [RES_W:0] held_r;
    logic [RES_W:0] held_nxt;
    logic [9:0] gidx;
    logic [7:0] ofs;
    logic hit;
    logic req;
    logic rd;
    logic wr;
    logic wd;
    logic hb;
    logic lb;
    logic res_hit;
    logic [3:0] rch;
    logic [15:0] rword;

    // ------------------------------------------------------------
    // converter engine and clock divider
    // ------------------------------------------------------------
    adcs_link_if lnk();

    adcs_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .lnk(lnk.divider)
    );

    adcs_engine u_eng (
        .clk(clk),
        .rst_n(rst_n),
        .lnk(lnk.engine)
    );

    assign lnk.hold = cfg_r[ADCS_CFG_SOFT_RST];
    assign lnk.ps = cfg_r[2:0];
    assign lnk.mask = mask_r;
    assign lnk.start = start_r;
    assign lnk.abort = abort_r;
    assign lnk.repeat_en = cfg_r[ADCS_CFG_REPEAT];

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    always_comb begin
        gidx = avs_address[ADCS_ADDR_W-1:2];
        ofs = gidx[7:0];
        hit = (gidx[9:8] == ADCS_BASE_BLOCK[9:8]) ||
              (gidx[9:8] == ADCS_BASE_NONBLOCK[9:8]);
        // one answer per request: waitrequest is high when a request is taken
        req = (avs_read || avs_write) && wait_r;
        rd = req && avs_read && hit;
        wr = req && avs_write && hit;
        wd = !ofs[0] && avs_byteenable[1] && avs_byteenable[0];
        hb = !ofs[0] && avs_byteenable[1] && !avs_byteenable[0];
        lb = avs_byteenable[0] && (ofs[0] || !avs_byteenable[1]);
        res_hit = (ofs >= ADCS_OFS_RESULT) && (ofs <= ADCS_OFS_RESULT_END);
        rch = 4'((ofs - ADCS_OFS_RESULT) >> 1);
        rword = 16'(res_r[rch]) << PAD_W;
    end

    // ------------------------------------------------------------
    // register file next state
    // ------------------------------------------------------------
    always_comb begin
        cfg_nxt = cfg_r;
        mask_nxt = mask_r;
        done_nxt = done_r;
        scf_nxt = scf_r;
        res_nxt = res_r;
        lat_hi_nxt = lat_hi_r;
        lat_ch_nxt = lat_ch_r;
        lat_vld_nxt = lat_vld_r;
        start_nxt = 1'b0;
        abort_nxt = 1'b0;
        wait_nxt = 1'b1;
        rdata_nxt = rdata_r;
        held_nxt = held_r;
        // analog side is asynchronous: accept only a settled value
        if (s2_r == s3_r) begin
            held_nxt = s3_r;
        end
        lim_nxt = held_r[RES_W];
        if (req) begin
            wait_nxt = 1'b0;
            rdata_nxt = 32'h00000000;
        end
        if (rd) begin
            if (ofs == ADCS_OFS_CONFIG) begin
                rdata_nxt = {24'h000000, cfg_r};
            end else if (ofs == ADCS_OFS_STATUS) begin
                rdata_nxt = {24'h000000, scf_r, lim_r, 2'h0, lnk.cnt};
                scf_nxt = 1'b0;
            end else if (ofs == ADCS_OFS_MASK || ofs == ADCS_OFS_MASK_LO) begin
                rdata_nxt = rd16(mask_r, ofs[0]);
            end else if (ofs == ADCS_OFS_DONE || ofs == ADCS_OFS_DONE_LO) begin
                rdata_nxt = rd16(done_r & ADCS_CH_IMPL, ofs[0]);
            end else if (res_hit) begin
                if (wd) begin
                    rdata_nxt = {16'h0000, rword};
                    done_nxt[rch] = 1'b0;
                end else if (hb) begin
                    // high byte pairs with a preceding low byte of the same channel
                    rdata_nxt[15:8] = (lat_vld_r && lat_ch_r == rch) ?
                                      lat_hi_r : rword[15:8];
                    lat_vld_nxt = 1'b0;
                    done_nxt[rch] = 1'b0;
                end else if (lb) begin
                    rdata_nxt[7:0] = rword[7:0];
                    lat_hi_nxt = rword[15:8];
                    lat_ch_nxt = rch;
                    lat_vld_nxt = 1'b1;
                end
            end
        end
        if (wr) begin
            if (ofs == ADCS_OFS_CONFIG && avs_byteenable[0]) begin
                cfg_nxt = avs_writedata[7:0] & ADCS_CFG_WMASK;
            end else if (ofs[7:1] == ADCS_OFS_MASK[7:1]) begin
                if (hb || wd) begin
                    mask_nxt[15:8] = avs_writedata[15:8];
                end
                if (lb || wd) begin
                    mask_nxt[7:0] = avs_writedata[7:0];
                end
                mask_nxt = mask_nxt & ADCS_CH_IMPL;
                done_nxt = ADCS_DONE_RESET;
                abort_nxt = 1'b1;
                start_nxt = (hb || wd) && (mask_nxt != ADCS_MASK_RESET);
            end
        end
        // hardware sets come after the bus clears so a same-cycle event survives them; the soft reset clears come last and win
        if (lnk.ch_done) begin
            done_nxt[lnk.cnt] = 1'b1;
            res_nxt[lnk.cnt] = held_r[RES_W-1:0];
        end
        if (lnk.seq_done) begin
            scf_nxt = 1'b1;
        end
        if (cfg_r[ADCS_CFG_SOFT_RST]) begin
            mask_nxt = ADCS_MASK_RESET;
            done_nxt = ADCS_DONE_RESET;
            scf_nxt = 1'b0;
            lim_nxt = 1'b0;
            for (int i = 0; i < 16; i++) begin
                res_nxt[i] = '0;
            end
            lat_vld_nxt = 1'b0;
            start_nxt = 1'b0;
            abort_nxt = 1'b0;
        end
        irq_nxt = scf_nxt && cfg_nxt[ADCS_CFG_IRQ_EN];
    end

    // ------------------------------------------------------------
    // register file state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= ADCS_CONFIG_RESET;
            mask_r <= ADCS_MASK_RESET;
            done_r <= ADCS_DONE_RESET;
            scf_r <= 1'b0;
            lim_r <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                res_r[i] <= '0;
            end
            lat_hi_r <= 8'h00;
            lat_ch_r <= 4'h0;
            lat_vld_r <= 1'b0;
            start_r <= 1'b0;
            abort_r <= 1'b0;
            rdata_r <= 32'h00000000;
            wait_r <= 1'b1;
            irq_r <= 1'b0;
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            held_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
            mask_r <= mask_nxt;
            done_r <= done_nxt;
            scf_r <= scf_nxt;
            lim_r <= lim_nxt;
            res_r <= res_nxt;
            lat_hi_r <= lat_hi_nxt;
            lat_ch_r <= lat_ch_nxt;
            lat_vld_r <= lat_vld_nxt;
            start_r <= start_nxt;
            abort_r <= abort_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            irq_r <= irq_nxt;
            s1_r <= {ref_limit_pin, ana_result};
            s2_r <= s1_r;
            s3_r <= s2_r;
            held_r <= held_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign irq = irq_r;
    assign ana_channel = lnk.cnt;
    assign ana_sample = lnk.sampling;
    assign offset_comp_en = cfg_r[ADCS_CFG_OFFSET];
endmodule

/* File: testbench/adcs_ana_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// analog front end stand-in
// ----------------------------------------
// result tied to the channel so that a wrong channel shows in the data
module adcs_ana_model (
    input wire logic [3:0] ana_channel,
    output logic [9:0] ana_result
);
    assign ana_result = {ana_channel, 6'h2a} ^ 10'h155;
endmodule

/* File: testbench/adcs_top_chk.sv */
`timescale 1ns/100ps
// ----------------------------------------
// port checker
// ----------------------------------------
module adcs_top_chk #(
    parameter int RES_W = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [adcs_pkg::ADCS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [3:0] ana_channel,
    input wire logic ana_sample,
    input wire logic irq
);
    import adcs_pkg::*;
    logic [7:0] ofs;
    assign ofs = avs_address[9:2];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rd_hit;
        s_take ##0 avs_read && avs_address[11];
    endsequence
    property p_answer;
        s_take |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("answer not one cycle");
    property p_no_spont;
        !avs_waitrequest |-> $past(avs_read || avs_write) && $past(avs_waitrequest);
    endproperty
    a_no_spont: assert property (p_no_spont) else $error("answer without request");
    property p_unmapped;
        s_take ##0 avs_read && !avs_address[11] |=> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_res_low;
        s_rd_hit ##0 ofs >= 8'h86 && ofs <= 8'ha5 |=> avs_readdata[5:0] == 6'h00;
    endproperty
    a_res_low: assert property (p_res_low) else $error("result low bits set");
    property p_stat_fmt;
        s_rd_hit ##0 ofs == 8'h81 |=> avs_readdata[5:4] == 2'b00;
    endproperty
    a_stat_fmt: assert property (p_stat_fmt) else $error("status spare bits set");
    property p_ch13;
        s_rd_hit ##0 ofs == 8'h84 |=> avs_readdata[13] == 1'b0;
    endproperty
    a_ch13: assert property (p_ch13) else $error("done bit 13 set");
    // unselected channels are skipped, so the counter only moves forward or restarts at 15
    property p_order;
        $changed(ana_channel) |->
            4'(ana_channel + 4'h1) > 4'($past(ana_channel) + 4'h1) || ana_channel == 4'hf;
    endproperty
    a_order: assert property (p_order) else $error("channel out of scan order");
    property p_samp_hold;
        ana_sample && $past(ana_sample) |-> $stable(ana_channel);
    endproperty
    a_samp_hold: assert property (p_samp_hold) else $error("channel moved in sampling");
    property p_reset_vals;
        $rose(rst_n) |-> ana_channel == 4'hf && !ana_sample && !irq;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
endmodule
bind adcs_top adcs_top_chk #(.RES_W(RES_W)) u_chk (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ana_channel(ana_channel), .ana_sample(ana_sample), .irq(irq));

/* File: testbench/test_adc_sequence_control.sv */
`timescale 1ns/100ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module test_adc_sequence_control;
    import adcs_pkg::*;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, ref_limit_pin;
    logic ana_sample, offset_comp_en, irq;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable, ana_channel, ch;
    logic [9:0] ana_result;
    logic [15:0] e;
    int fail_count = 0, num_checks = 0, cyc = 0, n, w;
    adcs_top u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ana_result(ana_result),
        .ref_limit_pin(ref_limit_pin), .ana_channel(ana_channel), .ana_sample(ana_sample),
        .offset_comp_en(offset_comp_en), .irq(irq));
    adcs_ana_model u_ana (.ana_channel(ana_channel), .ana_result(ana_result));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ----------------------------------------
    // hang guard and closing
    // ----------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // bus and observation tasks
    // ----------------------------------------
    function automatic logic [15:0] exp_res(input logic [3:0] c);
        return {{c, 6'h2a} ^ 10'h155, 6'h00};
    endfunction
    task automatic acc(input logic wt, input logic [9:0] ix, input logic [15:0] d,
        input logic [1:0] be);
        @(posedge clk);
        avs_address <= {ix, 2'b00};
        avs_write <= wt;
        avs_read <= !wt;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= {2'b00, be};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] o, input logic [15:0] d, input logic [1:0] be);
        acc(1'b1, {2'b10, o}, d, be);
    endtask
    task automatic rd(input logic [7:0] o, input logic [1:0] be);
        acc(1'b0, {2'b10, o}, 16'h0000, be);
    endtask
    // bounded wait for a sampling phase: channel, length, cycles waited
    task automatic samp(output logic [3:0] c, output int len, output int wt);
        len = 0;
        wt = 0;
        while (wt < 200 && ana_sample !== 1'b1) begin wt++; @(posedge clk); end
        c = ana_channel;
        while (ana_sample === 1'b1) begin len++; @(posedge clk); end
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 12'h000;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        ref_limit_pin = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h81, 2'b01); `CHK("status", 32'h0f, q)
        rd(8'h82, 2'b11); `CHK("mask", 32'h0, q)
        rd(8'h9a, 2'b11); `CHK("res10", 32'h0, q)
        $display("test reset done");
        wr(8'h80, 16'h0085, 2'b01);
        wr(8'h82, 16'h0400, 2'b11);
        samp(ch, n, w); `CHK("ch", 4'ha, ch)
        `CHK("slen", 9, n)
        rd(8'h84, 2'b11); `CHK("busy", 32'h0, q)
        repeat (20) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        rd(8'h84, 2'b11); `CHK("done", 32'h0400, q)
        rd(8'h81, 2'b01); `CHK("seq", 1'b1, q[7])
        rd(8'h81, 2'b01); `CHK("seq2", 1'b0, q[7])
        `CHK("irq0", 1'b0, irq)
        rd(8'h9a, 2'b11); `CHK("r10", {16'h0, exp_res(4'ha)}, q)
        rd(8'h84, 2'b11); `CHK("clr", 32'h0, q)
        $display("test single done");
        ref_limit_pin <= 1'b1;
        wr(8'h82, 16'h8400, 2'b11);
        samp(ch, n, w); `CHK("first", 4'hf, ch)
        samp(ch, n, w); `CHK("second", 4'ha, ch)
        `CHK("gap", 22, w)
        repeat (20) @(posedge clk);
        rd(8'h84, 2'b10); `CHK("donehi", 8'h84, q[15:8])
        rd(8'h85, 2'b01); `CHK("donelo", 8'h00, q[7:0])
        rd(8'h81, 2'b01); `CHK("lim", 1'b1, q[6])
        e = exp_res(4'hf);
        rd(8'ha5, 2'b01); `CHK("lo", e[7:0], q[7:0])
        rd(8'h84, 2'b11); `CHK("keep", 32'h8400, q)
        rd(8'ha4, 2'b10); `CHK("hi", e[15:8], q[15:8])
        rd(8'h84, 2'b11); `CHK("hiclr", 32'h0400, q)
        $display("test order done");
        wr(8'h82, 16'h4000, 2'b11);
        rd(8'h84, 2'b11); `CHK("wclr", 32'h0, q)
        wr(8'h82, 16'h0001, 2'b11);
        samp(ch, n, w); `CHK("abort", 4'h0, ch)
        wr(8'h82, 16'h0000, 2'b11);
        samp(ch, n, w); `CHK("stop", 0, n)
        wr(8'h83, 16'h0002, 2'b01);
        samp(ch, n, w); `CHK("lowb", 0, n)
        wr(8'h82, 16'h8000, 2'b10);
        samp(ch, n, w); `CHK("hib", 4'hf, ch)
        samp(ch, n, w); `CHK("hib1", 4'h1, ch)
        rd(8'h82, 2'b11); `CHK("mrd", 32'h8002, q)
        wr(8'h82, 16'h2000, 2'b11);
        rd(8'h82, 2'b11); `CHK("ch13", 32'h0, q)
        $display("test abort done");
        wr(8'h80, 16'h0065, 2'b01); `CHK("oce", 1'b1, offset_comp_en)
        wr(8'h82, 16'h0001, 2'b11);
        samp(ch, n, w); `CHK("rep1", 4'h0, ch)
        samp(ch, n, w); `CHK("rep2", 4'h0, ch)
        `CHK("irqoff", 1'b0, irq)
        wr(8'h80, 16'h0055, 2'b01);
        acc(1'b0, {2'b11, 8'h81}, 16'h0000, 2'b01); `CHK("srst", 32'h0f, q)
        rd(8'h82, 2'b11); `CHK("srmask", 32'h0, q)
        acc(1'b0, {2'b01, 8'h81}, 16'h0000, 2'b01); `CHK("unmap", 32'h0, q)
        wr(8'h80, 16'h0004, 2'b01);
        wr(8'h82, 16'h0001, 2'b11);
        samp(ch, n, w); `CHK("resume", 18, n)
        $display("test repeat done");
        test_done();
    end
endmodule
